// ==== core/arwd_consts.svh ====
`ifndef ARWD_CONSTS_SVH
`define ARWD_CONSTS_SVH

// Register indices; byte address is four times the index
`define ARWD_IDX_CFG 8'hbc
`define ARWD_IDX_CTRL 8'hbd
`define ARWD_IDX_RES_LO 8'hbe
`define ARWD_IDX_RES_HI 8'hbf
`define ARWD_IDX_GT_LO 8'hc4
`define ARWD_IDX_GT_HI 8'hc5
`define ARWD_IDX_LT_LO 8'hc6
`define ARWD_IDX_LT_HI 8'hc7
`define ARWD_IDX_ISTAT 8'hc8
`define ARWD_IDX_IMASK 8'hc9

// Reset values
`define ARWD_RST_CFG 8'hf8
`define ARWD_RST_RES 8'h00
`define ARWD_RST_GT 8'hff
`define ARWD_RST_LT 8'h00

// Control register bit positions
`define ARWD_CTRL_EN 7
`define ARWD_CTRL_BUSY 4
`define ARWD_CTRL_WIN 1
`define ARWD_CTRL_LEFT 0

// Config divider field position
`define ARWD_CFG_DIV_HI 7
`define ARWD_CFG_DIV_LO 5

// Interrupt status and mask bit positions
`define ARWD_EV_DONE 0
`define ARWD_EV_WIN 1

// System clocks per conversion at undivided setting
`define ARWD_CONV_CLKS 16

`endif

// ==== core/arwd_pkg.sv ====
package arwd_pkg;
  localparam int ADR_W = 10;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } arwd_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } arwd_wb_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_CMP = 3'b100
  } arwd_state_t;

  typedef struct packed {
    arwd_state_t st;
    logic [7:0] cnt;
    logic en;
    logic left;
    logic [7:0] cfg;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic [7:0] gt_hi;
    logic [7:0] gt_lo;
    logic [7:0] lt_hi;
    logic [7:0] lt_lo;
    logic [1:0] istat;
    logic [1:0] imask;
    logic ack;
    logic [31:0] rdat;
    logic irq;
    logic busy;
  } arwd_regs_t;
endpackage

// ==== core/arwd_fmt.sv ====
`timescale 1ns/1ps
module arwd_fmt (
  input wire logic [9:0] sample,
  input wire logic left,
  output logic [7:0] hi,
  output logic [7:0] lo
);
  // Left keeps the top eight bits high; right sign-extends bit nine upward
  always_comb begin
    if (left) begin
      hi = sample[9:2];
      lo = {sample[1:0], 6'h00};
    end else begin
      hi = {{6{sample[9]}}, sample[9:8]};
      lo = sample[7:0];
    end
  end
endmodule

// ==== core/arwd_win.sv ====
`timescale 1ns/1ps
module arwd_win (
  input wire logic [15:0] word,
  input wire logic [15:0] gt,
  input wire logic [15:0] lt,
  input wire logic signed_mode,
  output logic hit
);
  logic lt_above_gt;
  logic below_lt;
  logic above_gt;

  // Signed compare only for sign-extended right-justified data
  always_comb begin
    if (signed_mode) begin
      lt_above_gt = $signed(lt) > $signed(gt);
      below_lt = $signed(word) < $signed(lt);
      above_gt = $signed(word) > $signed(gt);
    end else begin
      lt_above_gt = lt > gt;
      below_lt = word < lt;
      above_gt = word > gt;
    end
    // Inside window when limits cross, outside otherwise
    if (lt_above_gt) begin
      hit = below_lt && above_gt;
    end else begin
      hit = below_lt || above_gt;
    end
  end
endmodule

// ==== core/arwd_top.sv ====
`timescale 1ns/1ps
`include "arwd_consts.svh"
module arwd_top #(
  parameter int CONV_CLKS = `ARWD_CONV_CLKS
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire arwd_pkg::arwd_wb_req_t wb_req,
  output arwd_pkg::arwd_wb_rsp_t wb_rsp,
  input wire logic conv_start,
  input wire logic [9:0] conv_sample,
  output logic conv_busy,
  output logic irq
);
  import arwd_pkg::*;

  // Counter is eight bits; longest divided conversion must fit
  if (CONV_CLKS < `ARWD_CONV_CLKS || CONV_CLKS * 8 > 256) begin : g_bad_conv_clks
    $error("CONV_CLKS out of range");
  end

  localparam logic [7:0] CONV_CLKS_B = CONV_CLKS[7:0];

  arwd_regs_t r_reg;
  arwd_regs_t r_next;

  logic [7:0] fmt_hi;
  logic [7:0] fmt_lo;
  logic win_hit;
  logic [15:0] gt_word;
  logic [15:0] lt_word;
  logic [15:0] res_word;

  // Address decode, used for both reads and writes
  function automatic logic hit_idx(input logic [ADR_W-1:0] adr, input logic [7:0] idx);
    hit_idx = (adr[ADR_W-1:2] == idx) && (adr[1:0] == 2'b00);
  endfunction

  // Conversion length scales with the divider field
  function automatic logic [7:0] conv_len(input logic [2:0] div);
    logic [10:0] prod;
    prod = 11'(CONV_CLKS_B) * (11'(div) + 11'h001);
    conv_len = prod[7:0] - 8'h01;
  endfunction

  // Limit words are the high byte over the low byte
  assign gt_word = {r_reg.gt_hi, r_reg.gt_lo};
  assign lt_word = {r_reg.lt_hi, r_reg.lt_lo};
  assign res_word = {r_reg.res_hi, r_reg.res_lo};

  arwd_fmt u_fmt (
    .sample(conv_sample),
    .left(r_reg.left),
    .hi(fmt_hi),
    .lo(fmt_lo)
  );

  // Compare uses the stored result so a software write cannot race it
  arwd_win u_win (
    .word(res_word),
    .gt(gt_word),
    .lt(lt_word),
    .signed_mode(!r_reg.left),
    .hit(win_hit)
  );

  logic req;
  logic wr;
  logic start_sw;
  logic start_any;
  logic [1:0] ev_set;
  logic [1:0] ev_clr;
  logic [1:0] istat_new;
  logic [7:0] rd_byte;

  always_comb begin
    r_next = r_reg;
    ev_set = 2'b00;
    ev_clr = 2'b00;
    start_sw = 1'b0;
    rd_byte = 8'h00;

    // One request per bus cycle; ack blocks the repeat edge
    req = wb_req.cyc && wb_req.stb && !r_reg.ack;
    wr = req && wb_req.we && wb_req.sel[0];
    r_next.ack = req;

    // Register writes; only the low byte lane carries data
    if (wr) begin
      if (hit_idx(wb_req.adr, `ARWD_IDX_CFG)) begin
        r_next.cfg = wb_req.dat[7:0];
      end
      if (hit_idx(wb_req.adr, `ARWD_IDX_CTRL)) begin
        r_next.en = wb_req.dat[`ARWD_CTRL_EN];
        r_next.left = wb_req.dat[`ARWD_CTRL_LEFT];
        start_sw = wb_req.dat[`ARWD_CTRL_BUSY];
      end
      if (hit_idx(wb_req.adr, `ARWD_IDX_RES_LO)) begin
        r_next.res_lo = wb_req.dat[7:0];
      end
      if (hit_idx(wb_req.adr, `ARWD_IDX_RES_HI)) begin
        r_next.res_hi = wb_req.dat[7:0];
      end
      if (hit_idx(wb_req.adr, `ARWD_IDX_GT_LO)) begin
        r_next.gt_lo = wb_req.dat[7:0];
      end
      if (hit_idx(wb_req.adr, `ARWD_IDX_GT_HI)) begin
        r_next.gt_hi = wb_req.dat[7:0];
      end
      if (hit_idx(wb_req.adr, `ARWD_IDX_LT_LO)) begin
        r_next.lt_lo = wb_req.dat[7:0];
      end
      if (hit_idx(wb_req.adr, `ARWD_IDX_LT_HI)) begin
        r_next.lt_hi = wb_req.dat[7:0];
      end
      if (hit_idx(wb_req.adr, `ARWD_IDX_ISTAT)) begin
        ev_clr = wb_req.dat[1:0];
      end
      if (hit_idx(wb_req.adr, `ARWD_IDX_IMASK)) begin
        r_next.imask = wb_req.dat[1:0];
      end
    end

    // Starts are ignored while disabled or already converting
    start_any = r_reg.en && (start_sw || conv_start);

    // Conversion sequencer
    case (r_reg.st)
      ST_IDLE: begin
        if (start_any) begin
          r_next.st = ST_CONV;
          r_next.cnt = conv_len(r_reg.cfg[`ARWD_CFG_DIV_HI:`ARWD_CFG_DIV_LO]);
          r_next.busy = 1'b1;
        end
      end
      ST_CONV: begin
        if (r_reg.cnt == 8'h00) begin
          // Hardware result wins over a same-cycle software write
          r_next.res_hi = fmt_hi;
          r_next.res_lo = fmt_lo;
          r_next.st = ST_CMP;
        end else begin
          r_next.cnt = r_reg.cnt - 8'h01;
        end
      end
      ST_CMP: begin
        // Each finished result is checked once, with no software step
        ev_set[`ARWD_EV_DONE] = 1'b1;
        ev_set[`ARWD_EV_WIN] = win_hit;
        r_next.busy = 1'b0;
        r_next.st = ST_IDLE;
      end
      default: begin
        r_next.st = ST_IDLE;
        r_next.busy = 1'b0;
      end
    endcase

    // Sticky events; a set in the clearing cycle survives
    istat_new = (r_reg.istat & ~ev_clr) | ev_set;
    r_next.istat = istat_new;

    // Level interrupt from unmasked sticky bits
    r_next.irq = |(istat_new & r_next.imask);

    // Read mux; unmapped addresses read zero
    if (hit_idx(wb_req.adr, `ARWD_IDX_CFG)) begin
      rd_byte = r_reg.cfg;
    end else if (hit_idx(wb_req.adr, `ARWD_IDX_CTRL)) begin
      rd_byte[`ARWD_CTRL_EN] = r_reg.en;
      rd_byte[`ARWD_CTRL_BUSY] = r_reg.busy;
      rd_byte[`ARWD_CTRL_WIN] = r_reg.istat[`ARWD_EV_WIN];
      rd_byte[`ARWD_CTRL_LEFT] = r_reg.left;
    end else if (hit_idx(wb_req.adr, `ARWD_IDX_RES_LO)) begin
      rd_byte = r_reg.res_lo;
    end else if (hit_idx(wb_req.adr, `ARWD_IDX_RES_HI)) begin
      rd_byte = r_reg.res_hi;
    end else if (hit_idx(wb_req.adr, `ARWD_IDX_GT_LO)) begin
      rd_byte = r_reg.gt_lo;
    end else if (hit_idx(wb_req.adr, `ARWD_IDX_GT_HI)) begin
      rd_byte = r_reg.gt_hi;
    end else if (hit_idx(wb_req.adr, `ARWD_IDX_LT_LO)) begin
      rd_byte = r_reg.lt_lo;
    end else if (hit_idx(wb_req.adr, `ARWD_IDX_LT_HI)) begin
      rd_byte = r_reg.lt_hi;
    end else if (hit_idx(wb_req.adr, `ARWD_IDX_ISTAT)) begin
      rd_byte = {6'h00, r_reg.istat};
    end else if (hit_idx(wb_req.adr, `ARWD_IDX_IMASK)) begin
      rd_byte = {6'h00, r_reg.imask};
    end
    // Read data shows pre-write contents of the same cycle
    r_next.rdat = req ? {24'h000000, rd_byte} : 32'h00000000;
  end

  // Single state register; synchronous active-low reset
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      r_reg.st <= ST_IDLE;
      r_reg.cnt <= 8'h00;
      r_reg.en <= 1'b0;
      r_reg.left <= 1'b0;
      r_reg.cfg <= `ARWD_RST_CFG;
      r_reg.res_hi <= `ARWD_RST_RES;
      r_reg.res_lo <= `ARWD_RST_RES;
      r_reg.gt_hi <= `ARWD_RST_GT;
      r_reg.gt_lo <= `ARWD_RST_GT;
      r_reg.lt_hi <= `ARWD_RST_LT;
      r_reg.lt_lo <= `ARWD_RST_LT;
      r_reg.istat <= 2'b00;
      r_reg.imask <= 2'b00;
      r_reg.ack <= 1'b0;
      r_reg.rdat <= 32'h00000000;
      r_reg.irq <= 1'b0;
      r_reg.busy <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign wb_rsp.ack = r_reg.ack;
  assign wb_rsp.dat = r_reg.rdat;
  assign conv_busy = r_reg.busy;
  assign irq = r_reg.irq;
endmodule

// ==== dv/arwd_top_properties.sv ====
`timescale 1ns/1ps
module arwd_top_properties #(
  parameter int CONV_CLKS = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire arwd_pkg::arwd_wb_req_t wb_req,
  input wire arwd_pkg::arwd_wb_rsp_t wb_rsp,
  input wire logic conv_start,
  input wire logic [9:0] conv_sample,
  input wire logic conv_busy,
  input wire logic irq
);
  import arwd_pkg::*;
  logic [7:0] busy_reg;
  logic take;
  // Busy length; eight bits cover the slowest divider for CONV_CLKS up to 31
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      busy_reg <= 8'h00;
    end else begin
      busy_reg <= conv_busy ? busy_reg + 8'h01 : 8'h00;
    end
  end
  // A request is taken only while ack is low
  assign take = wb_req.cyc & wb_req.stb & !wb_rsp.ack;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ack_latency_a: assert property (take |=> wb_rsp.ack) else $error("ack late");
  ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack held");
  ack_cause_a: assert property (wb_rsp.ack |-> $past(take)) else $error("ack unasked");
  dat_idle_a: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0) else $error("dat idle");
  dat_upper_a: assert property (wb_rsp.dat[31:8] == 24'h0) else $error("dat upper");
  bad_adr_a: assert property (take && wb_req.adr[1:0] != 2'h0 |=> wb_rsp.dat == 32'h0)
    else $error("misaligned read");
  // Counter lags busy by one edge, so at the fall it equals the number of high cycles
  busy_len_a: assert property ($fell(conv_busy) |-> busy_reg >= CONV_CLKS &&
    busy_reg <= CONV_CLKS * 8) else $error("busy length");
  irq_rise_a: assert property ($rose(irq) |-> $fell(conv_busy) ||
    $past(wb_req.cyc & wb_req.we)) else $error("irq rise");
  irq_sticky_a: assert property ($fell(irq) |-> $past(wb_req.cyc & wb_req.we))
    else $error("irq fall");
endmodule
bind arwd_top arwd_top_properties #(.CONV_CLKS(CONV_CLKS)) u_props (.core_clk(core_clk),
  .nrst(nrst), .wb_req(wb_req), .wb_rsp(wb_rsp), .conv_start(conv_start),
  .conv_sample(conv_sample), .conv_busy(conv_busy), .irq(irq));

// ==== dv/arwd_top_bench.sv ====
`timescale 1ns/1ps
`include "arwd_consts.svh"
module arwd_top_bench;
  import arwd_pkg::*;
  localparam int N = 16;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  arwd_wb_req_t wb_req = '0;
  arwd_wb_rsp_t wb_rsp;
  logic conv_start = 1'b0;
  logic [9:0] conv_sample = 10'h000;
  logic conv_busy;
  logic irq;
  logic [7:0] rd;
  int err_count = 0;
  int num_checks = 0;
  // Reset values as index and expected byte; 0x10 is unmapped
  logic [15:0] rv [11] = '{16'hbcf8, 16'hbd00, 16'hbe00, 16'hbf00, 16'hc4ff, 16'hc5ff,
    16'hc600, 16'hc700, 16'hc800, 16'hc900, 16'h1000};
  always #4 core_clk = ~core_clk;
  arwd_top #(.CONV_CLKS(N)) u_dut (.core_clk(core_clk), .nrst(nrst), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .conv_start(conv_start), .conv_sample(conv_sample),
    .conv_busy(conv_busy), .irq(irq));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; waits for ack, takes read data at that edge
  task automatic wb(input logic we, input logic [9:0] adr, input logic [7:0] wd);
    @(posedge core_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, wd}};
    do @(posedge core_clk); while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat[7:0];
    wb_req <= '0;
  endtask
  // Window expectation; sign extension only when right justified
  function automatic logic win_exp(input logic [15:0] x, g, l, input logic sg);
    logic signed [16:0] xs, gs, ls;
    xs = {sg & x[15], x};
    gs = {sg & g[15], g};
    ls = {sg & l[15], l};
    return (ls > gs) ? (xs > gs && xs < ls) : (xs < ls || xs > gs);
  endfunction
  task automatic conv(input logic left, input logic [9:0] s, input logic [15:0] g, l);
    logic [7:0] eh, el;
    logic h;
    int k;
    eh = left ? s[9:2] : {{6{s[9]}}, s[9:8]};
    el = left ? {s[1:0], 6'h00} : s[7:0];
    h = win_exp({eh, el}, g, l, !left);
    k = 0;
    wb(1'b1, {`ARWD_IDX_GT_HI, 2'b00}, g[15:8]);
    wb(1'b1, {`ARWD_IDX_GT_LO, 2'b00}, g[7:0]);
    wb(1'b1, {`ARWD_IDX_LT_HI, 2'b00}, l[15:8]);
    wb(1'b1, {`ARWD_IDX_LT_LO, 2'b00}, l[7:0]);
    wb(1'b1, {`ARWD_IDX_CTRL, 2'b00}, {7'h40, left});
    // Start held into busy; the extra edges must be ignored
    @(posedge core_clk);
    conv_sample <= s;
    conv_start <= 1'b1;
    repeat (3) @(posedge core_clk);
    conv_start <= 1'b0;
    // Sample settled busy; two of its N+1 high cycles pass while start is held
    while (conv_busy === 1'b1 && k < 300) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    check(k[7:0], 8'(N - 1));
    wb(1'b0, {`ARWD_IDX_RES_HI, 2'b00}, 8'h00);
    check(rd, eh);
    wb(1'b0, {`ARWD_IDX_RES_LO, 2'b00}, 8'h00);
    check(rd, el);
    wb(1'b0, {`ARWD_IDX_ISTAT, 2'b00}, 8'h00);
    check(rd, {6'h0, h, 1'b1});
    wb(1'b0, {`ARWD_IDX_CTRL, 2'b00}, 8'h00);
    check({7'h0, rd[1]}, {7'h0, h});
    check({7'h0, irq}, {7'h0, h});
    wb(1'b1, {`ARWD_IDX_ISTAT, 2'b00}, 8'h03);
    wb(1'b0, {`ARWD_IDX_ISTAT, 2'b00}, 8'h00);
    check(rd, 8'h00);
    check({7'h0, irq}, 8'h00);
    $display("conversion test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (rv[i]) begin
      wb(1'b0, {rv[i][15:8], 2'b00}, 8'h00);
      check(rd, rv[i][7:0]);
    end
    wb(1'b0, {`ARWD_IDX_CFG, 2'b01}, 8'h00);
    check(rd, 8'h00);
    wb(1'b1, {`ARWD_IDX_LT_LO, 2'b00}, 8'h5a);
    wb(1'b0, {`ARWD_IDX_LT_LO, 2'b00}, 8'h00);
    check(rd, 8'h5a);
    $display("register test done");
    wb(1'b1, {`ARWD_IDX_CFG, 2'b00}, 8'h00);
    wb(1'b1, {`ARWD_IDX_IMASK, 2'b00}, 8'h02);
    conv(1'b1, 10'h2a5, 16'h1000, 16'hf000);
    conv(1'b0, 10'h2a5, 16'h0000, 16'h0100);
    conv(1'b0, 10'h055, 16'h0200, 16'h0100);
    conv(1'b1, 10'h010, 16'h8000, 16'h0100);
    report_and_stop;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    report_and_stop;
  end
endmodule
